// ### timer_global_pkg.sv
// Notes on behaviour
// - Bits 31 to 16 of the global control register read as zero and ignore writes.
// - Bits 7 to 4 of the global control register are read-only and always read as zero.
// - In dual unchained mode with the upper timer enabled, the upper prescale count steps every clock.
// - When the prescale count equals the prescale period, the upper count steps next cycle and the prescale count clears.
// - In one-time enable mode the upper timer stops once the upper count matches the upper period.
// - In continuous enable mode the upper count clears at the next upper count step after matching the upper period and keeps going.
// - The upper prescale period lives in bits 11 to 8, and both it and the prescale count reset to zero.
// - Mode field bits 3 to 2: 00b selects 64-bit general purpose and 01b selects dual unchained.
// - Mode value 10b selects watchdog and 11b selects dual chained.
// - Upper reset bit low holds the upper half in reset and forces its output status low, keeping its count.
// - Lower reset bit low forces the lower output status low and floats the timer pin, keeping its count.
// - While the watchdog is active, writes to either half-reset bit are ignored.
package timer_global_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] global_control_addr = 12'h000;
    localparam logic [11:0] upper_status_addr   = 12'h004;

    localparam int prescale_count_lsb  = 12;
    localparam int prescale_period_lsb = 8;
    localparam int mode_lsb            = 2;
    localparam int upper_rs_bit        = 1;
    localparam int lower_rs_bit        = 0;

    localparam logic [3:0] prescale_reset_value = 4'h0;
    localparam logic [1:0] mode_reset_value     = 2'h0;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        mode_gp64      = 2'h0,
        mode_unchained = 2'h1,
        mode_watchdog  = 2'h2,
        mode_chained   = 2'h3
    } operating_mode_type;

    typedef enum logic [1:0] {
        ena_off        = 2'h0,
        ena_once       = 2'h1,
        ena_continuous = 2'h2,
        ena_reserved   = 2'h3
    } enable_mode_type;

    typedef struct packed {
        logic [3:0]         upper_prescale_count;
        logic [3:0]         upper_prescale_period;
        operating_mode_type operating_mode_select;
        logic               upper_half_run_n_reset;
        logic               lower_half_run_n_reset;
    } global_control_type;

endpackage

// ### upper_prescaler.sv
module upper_prescaler
    import timer_global_pkg::*;
#(
    parameter int width = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             run,
    input  wire logic [width-1:0] period,
    input  wire logic             sw_load,
    input  wire logic [width-1:0] sw_value,
    // Status
    output logic      [width-1:0] count_ff,
    output logic                  tick_ff
);
    logic [width-1:0] nxt_count;
    logic             nxt_tick;

    // Refused at elaboration: a zero-width count cannot divide
    if (width < 1) begin
        $error("upper_prescaler width must be at least 1");
    end

    always_comb begin
        nxt_count = count_ff;
        nxt_tick  = 1'b0;
        if (sw_load) begin
            nxt_count = sw_value;
        end else if (run) begin
            if (count_ff == period) begin
                nxt_count = '0;
                nxt_tick  = 1'b1;
            end else begin
                nxt_count = count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff  <= nxt_tick;
        end
    end
endmodule

// ### timer_global_control.sv
// Added by the designer: the APB interface to the registers and the register offsets.
module timer_global_control
    import timer_global_pkg::*;
#(
    parameter int count_width = 32
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Upper half control
    input  wire logic [1:0]             upper_enable_mode,
    input  wire logic [count_width-1:0] upper_period_value,
    input  wire logic                   watchdog_active,
    input  wire logic                   upper_output_raw,
    input  wire logic                   lower_output_raw,
    output logic      [count_width-1:0] upper_count_value,
    output logic                        upper_count_step,
    output logic                        upper_period_match,
    // Decoded mode and half resets
    output operating_mode_type          operating_mode_select,
    output logic                        upper_half_run_n_reset,
    output logic                        lower_half_run_n_reset,
    // Output status and pin
    output logic                        upper_output_state,
    output logic                        lower_output_state,
    output logic                        timer_pin_out,
    output logic                        timer_pin_oe
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0]             period_ff, nxt_period;
    operating_mode_type     mode_ff, nxt_mode;
    logic                   hi_rs_ff, nxt_hi_rs;
    logic                   lo_rs_ff, nxt_lo_rs;
    logic [count_width-1:0] cnt_ff, nxt_cnt;
    logic                   stopped_ff, nxt_stopped;
    logic [31:0]            rdata_ff, nxt_rdata;
    logic [1:0]             ena_ff, nxt_ena;
    logic                   hi_state_ff, nxt_hi_state;
    logic                   lo_state_ff, nxt_lo_state;
    logic [3:0]             presc_count;
    logic                   presc_tick;
    logic                   upper_run;
    logic                   wr_ctrl;
    logic                   rd_access;
    logic                   match;
    global_control_type     view;

    // Refused at elaboration: the count must fit one bus word
    if (count_width < 1 || count_width > 32) begin
        $error("count_width must be 1 to 32");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its access phase
    assign pready    = 1'b1;
    assign wr_ctrl   = psel && penable && pwrite && paddr == global_control_addr;
    assign rd_access = psel && !penable && !pwrite;
    assign pslverr   = psel && penable && paddr != global_control_addr && paddr != upper_status_addr;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_comb begin
        nxt_period = period_ff;
        nxt_mode   = mode_ff;
        nxt_hi_rs  = hi_rs_ff;
        nxt_lo_rs  = lo_rs_ff;
        if (wr_ctrl) begin
            nxt_period = pwdata[prescale_period_lsb +: 4];
            nxt_mode   = operating_mode_type'(pwdata[mode_lsb +: 2]);
            // Watchdog running: half resets frozen to protect it
            if (!watchdog_active) begin
                nxt_hi_rs = pwdata[upper_rs_bit];
                nxt_lo_rs = pwdata[lower_rs_bit];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_ff <= prescale_reset_value;
            mode_ff   <= operating_mode_type'(mode_reset_value);
            hi_rs_ff  <= 1'b0;
            lo_rs_ff  <= 1'b0;
        end else begin
            period_ff <= nxt_period;
            mode_ff   <= nxt_mode;
            hi_rs_ff  <= nxt_hi_rs;
            lo_rs_ff  <= nxt_lo_rs;
        end
    end

    // ------------------------------------------------------------
    // Upper half prescale and count
    // ------------------------------------------------------------
    assign match     = cnt_ff == upper_period_value;
    assign upper_run = mode_ff == mode_unchained && hi_rs_ff && !stopped_ff
                       && (ena_ff == ena_once || ena_ff == ena_continuous);

    upper_prescaler #(
        .width    (4)
    ) prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (upper_run),
        .period   (period_ff),
        .sw_load  (wr_ctrl),
        .sw_value (pwdata[prescale_count_lsb +: 4]),
        .count_ff (presc_count),
        .tick_ff  (presc_tick)
    );

    always_comb begin
        nxt_cnt     = cnt_ff;
        nxt_stopped = stopped_ff;
        nxt_ena     = upper_enable_mode;
        // Re-arm a stopped one-shot when software changes the enable mode
        if (upper_enable_mode != ena_ff) begin
            nxt_stopped = 1'b0;
        end
        if (presc_tick && hi_rs_ff) begin
            if (match && ena_ff == ena_continuous) begin
                nxt_cnt = '0;
            end else if (match && ena_ff == ena_once) begin
                nxt_stopped = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
        if (match && ena_ff == ena_once && upper_enable_mode == ena_once) begin
            nxt_stopped = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff     <= '0;
            stopped_ff <= 1'b0;
            ena_ff     <= ena_off;
        end else begin
            cnt_ff     <= nxt_cnt;
            stopped_ff <= nxt_stopped;
            ena_ff     <= nxt_ena;
        end
    end

    // ------------------------------------------------------------
    // Output status and pin
    // ------------------------------------------------------------
    always_comb begin
        nxt_hi_state = hi_rs_ff ? upper_output_raw : 1'b0;
        nxt_lo_state = lo_rs_ff ? lower_output_raw : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_state_ff <= 1'b0;
            lo_state_ff <= 1'b0;
        end else begin
            hi_state_ff <= nxt_hi_state;
            lo_state_ff <= nxt_lo_state;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        view.upper_prescale_count   = presc_count;
        view.upper_prescale_period  = period_ff;
        view.operating_mode_select  = mode_ff;
        view.upper_half_run_n_reset = hi_rs_ff;
        view.lower_half_run_n_reset = lo_rs_ff;
    end

    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_access) begin
            nxt_rdata = 32'h0000_0000;
            if (paddr == global_control_addr) begin
                // Upper word and bits 7..4 stay zero
                nxt_rdata[15:8] = {view.upper_prescale_count, view.upper_prescale_period};
                nxt_rdata[3:0]  = {view.operating_mode_select,
                                   view.upper_half_run_n_reset, view.lower_half_run_n_reset};
            end else if (paddr == upper_status_addr) begin
                nxt_rdata[count_width-1:0] = cnt_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                 = rdata_ff;
    assign upper_count_value      = cnt_ff;
    assign upper_count_step       = presc_tick && hi_rs_ff;
    assign upper_period_match     = match;
    assign operating_mode_select  = mode_ff;
    assign upper_half_run_n_reset = hi_rs_ff;
    assign lower_half_run_n_reset = lo_rs_ff;
    assign upper_output_state     = hi_state_ff;
    assign lower_output_state     = lo_state_ff;
    assign timer_pin_out          = lo_state_ff;
    assign timer_pin_oe           = lo_rs_ff;
endmodule

// ### timer_global_control_asserts.sv
module timer_global_control_checker
    import timer_global_pkg::*;
#(
    parameter int count_width = 32
) (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // Register bus
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    // Timer side
    input wire logic [1:0]             upper_enable_mode,
    input wire logic                   watchdog_active,
    input wire logic [count_width-1:0] upper_count_value,
    input wire logic                   upper_count_step,
    input wire logic                   upper_period_match,
    input wire operating_mode_type     operating_mode_select,
    input wire logic                   upper_half_run_n_reset,
    input wire logic                   lower_half_run_n_reset,
    input wire logic                   upper_output_state,
    input wire logic                   lower_output_state,
    input wire logic                   timer_pin_oe
);
    // ----------------------------
    // Properties
    // ----------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire ctl_wr = psel && penable && pwrite && paddr == 12'h000;

    // Two cycles in reset, so a registered gate has surely closed
    sequence upper_held;
        !upper_half_run_n_reset ##1 !upper_half_run_n_reset;
    endsequence
    sequence lower_held;
        !lower_half_run_n_reset ##1 !lower_half_run_n_reset;
    endsequence

    a_reserved_zero: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
        prdata[31:16] == 16'h0 && prdata[7:4] == 4'h0) else $error("reserved bits not zero");
    a_mode_follows: assert property (ctl_wr |=> operating_mode_select == $past(pwdata[3:2]))
        else $error("mode field not decoded");
    a_wd_keeps_run: assert property (ctl_wr && watchdog_active |=> $stable(upper_half_run_n_reset)
        && $stable(lower_half_run_n_reset)) else $error("run bit changed in watchdog");
    a_upper_held: assert property (upper_held |-> !upper_output_state && $stable(upper_count_value))
        else $error("upper half not held");
    a_lower_held: assert property (lower_held |-> !lower_output_state && !timer_pin_oe)
        else $error("lower half not held");
    a_step_clears: assert property (upper_count_step && upper_period_match && upper_enable_mode == 2'h2
        |=> upper_count_value == '0) else $error("counter not cleared at period");
    a_once_stops: assert property (upper_period_match && upper_enable_mode == 2'h1 && $stable(upper_enable_mode)
        |=> $stable(upper_count_value)) else $error("one-shot did not stop");
    a_step_source: assert property (upper_count_step |-> $past(operating_mode_select) == mode_unchained
        && $past(upper_half_run_n_reset) && $past(upper_enable_mode, 2) != 2'h0) else $error("step outside run");
endmodule

// ### timer_global_control_tb.sv
module timer_global_control_tb
    import timer_global_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------
    // Signals and tasks
    // ----------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rd_err, upper_count_step, upper_period_match;
    logic [1:0] upper_enable_mode = 2'h0;
    logic [7:0] upper_period_value = 8'h0, upper_count_value, held;
    logic watchdog_active = 0, upper_output_raw = 0, lower_output_raw = 0;
    operating_mode_type operating_mode_select;
    logic upper_half_run_n_reset, lower_half_run_n_reset, upper_output_state, lower_output_state;
    logic timer_pin_out, timer_pin_oe;
    int error_cnt = 0, n_checks = 0, steps = 0;

    always #5 pclk = ~pclk;

    timer_global_control #(.count_width(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .upper_enable_mode(upper_enable_mode),
        .upper_period_value(upper_period_value), .watchdog_active(watchdog_active),
        .upper_output_raw(upper_output_raw), .lower_output_raw(lower_output_raw),
        .upper_count_value(upper_count_value), .upper_count_step(upper_count_step),
        .upper_period_match(upper_period_match), .operating_mode_select(operating_mode_select),
        .upper_half_run_n_reset(upper_half_run_n_reset), .lower_half_run_n_reset(lower_half_run_n_reset),
        .upper_output_state(upper_output_state), .lower_output_state(lower_output_state),
        .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe));

    task test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One transfer; returns with the answer taken at the pready edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            test_done();
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 0; penable <= 0;
        #1;
    endtask

    // ----------------------------
    // Sequence
    // ----------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 32'h0); chk(rd, 32'h0, "reset value");
        apb(1, 12'h000, 32'hffff_ffff);
        apb(0, 12'h000, 32'h0); chk(rd, 32'h0000_ff0f, "reserved bits");
        for (int m = 0; m < 4; m++) begin
            apb(1, 12'h000, {28'h0, m[1:0], 2'h3}); chk({30'h0, operating_mode_select}, m, "mode");
        end
        apb(0, 12'h0f0, 32'h0); chk({31'h0, rd_err}, 32'h1, "unmapped error");
        @(posedge pclk);
        upper_period_value <= 8'd3; upper_enable_mode <= 2'h2;
        upper_output_raw <= 1; lower_output_raw <= 1;
        apb(1, 12'h000, 32'h0000_0207);
        repeat (5) @(posedge pclk);
        repeat (30) begin
            @(posedge pclk);
            #1;
            if (upper_count_step === 1'b1) steps++;
        end
        chk(steps, 10, "prescaled steps");
        @(posedge pclk);
        upper_enable_mode <= 2'h1;
        repeat (20) @(posedge pclk);
        chk({23'h0, upper_period_match, upper_count_value}, 32'h0000_0103, "one-shot stop");
        apb(0, upper_status_addr, 32'h0); chk(rd, 32'd3, "count readback");
        @(posedge pclk);
        upper_enable_mode <= 2'h2;
        apb(1, 12'h000, 32'h0000_3205);
        held = upper_count_value;
        apb(0, 12'h000, 32'h0); chk(rd, 32'h0000_3205, "held prescale");
        repeat (5) @(posedge pclk);
        chk({24'h0, upper_count_value}, {24'h0, held}, "upper count kept");
        chk({29'h0, upper_output_state, lower_output_state, timer_pin_out}, 32'h3, "upper state");
        apb(1, 12'h000, 32'h0000_0206);
        repeat (3) @(posedge pclk);
        chk({29'h0, lower_output_state, timer_pin_oe, timer_pin_out}, 32'h0, "lower held");
        @(posedge pclk);
        watchdog_active <= 1;
        apb(1, 12'h000, 32'h0000_0009);
        chk({28'h0, operating_mode_select, upper_half_run_n_reset, lower_half_run_n_reset}, 32'ha, "wd");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        test_done();
    end
endmodule

bind timer_global_control timer_global_control_checker #(.count_width(count_width)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .upper_enable_mode(upper_enable_mode), .watchdog_active(watchdog_active),
    .upper_count_value(upper_count_value), .upper_count_step(upper_count_step),
    .upper_period_match(upper_period_match), .operating_mode_select(operating_mode_select),
    .upper_half_run_n_reset(upper_half_run_n_reset), .lower_half_run_n_reset(lower_half_run_n_reset),
    .upper_output_state(upper_output_state), .lower_output_state(lower_output_state),
    .timer_pin_oe(timer_pin_oe));
